// ===== sram_port_pkg.sv
// Shared constants and enumerations of the pipelined burst SRAM port
`default_nettype none
package sram_port_pkg;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int LANES = 4;
    localparam int LANE_DATA_W = 8;
    localparam int LANE_PAR_W = 1;
    localparam int LANE_W = LANE_DATA_W + LANE_PAR_W;
    localparam int ADDR_W = 18;
    localparam int BURST_BITS = 2;

    // ****************************************************************
    // Timing in clock cycles
    // ****************************************************************
    localparam int DATA_LATENCY = 2;
    localparam int BURST_LEN = 4;

    // ****************************************************************
    // Burst counter reset value and step
    // ****************************************************************
    localparam logic [BURST_BITS-1:0] BURST_COUNT_RESET = 2'h0;
    localparam logic [BURST_BITS-1:0] BURST_STEP = 2'h1;

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b10
    } op_t;

    typedef enum logic [1:0] {
        BURST_IDLE = 2'b00,
        BURST_READ = 2'b01,
        BURST_WRITE = 2'b10
    } burst_state_t;

endpackage
`default_nettype wire

// ===== burst_addr_gen.sv
// Low address bits of one burst beat, linear or interleaved order
`default_nettype none
module burst_addr_gen (
    // Burst start and beat
    input wire logic [sram_port_pkg::BURST_BITS-1:0] start_bits,
    input wire logic [sram_port_pkg::BURST_BITS-1:0] beat_count,
    // Order select, high for interleaved
    input wire logic interleaved,
    // Resulting low address bits
    output logic [sram_port_pkg::BURST_BITS-1:0] beat_bits
);

    always_comb begin
        if (interleaved) begin
            beat_bits = start_bits ^ beat_count;
        end else begin
            beat_bits = start_bits + beat_count;
        end
    end

endmodule // burst_addr_gen
`default_nettype wire

// ===== sram_burst_port.sv
// Pipelined burst SRAM with byte-lane writes and no bus turnaround
// Summary of operation
// - One active-low write select per 9-bit lane decides if that lane is written.
// - Lane selects are ignored on any read cycle.
// - Selected lanes of write data reach the array two cycles after the command.
// - Load with any chip select inactive starts a deselect cycle.
// - Data bus goes high impedance two cycles after a deselect starts.
// - All three chip selects must be true; the high one has inverted polarity.
// - All synchronous pins use the rising edge; only output enable and reset are asynchronous.
// - Write data in and read data out are both registered on the rising edge.
// - Burst order select high gives interleaved order, low gives linear order.
// - Output enable high keeps data pins high impedance; data drives only when low.
// - Load takes a new address and command; advance steps the burst counter.
// - Clock enable high freezes every register and the data outputs and ignores synchronous inputs; output enable still gates the pins.
// - Operations already in the pipeline complete before the bus goes idle.
// - One loaded address yields four beats before the address order repeats.
`default_nettype none
module sram_burst_port #(
    parameter int ADDR_W = sram_port_pkg::ADDR_W,
    parameter int LANES = sram_port_pkg::LANES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Command inputs
    input wire logic clk_enable_n,
    input wire logic advance_or_load,
    input wire logic read_write,
    input wire logic [ADDR_W-1:0] address,
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_b_n,
    input wire logic chip_sel_hi,
    input wire logic [LANES-1:0] byte_lane_write_n,
    // Static configuration
    input wire logic burst_order_sel,
    // Asynchronous output enable
    input wire logic output_enable_n,
    // Data pins
    input wire logic [LANES*sram_port_pkg::LANE_DATA_W-1:0] data_pins_in,
    output logic [LANES*sram_port_pkg::LANE_DATA_W-1:0] data_pins_out,
    output logic [LANES*sram_port_pkg::LANE_DATA_W-1:0] data_pins_oe,
    // Parity data pins
    input wire logic [LANES*sram_port_pkg::LANE_PAR_W-1:0] parity_data_pins_in,
    output logic [LANES*sram_port_pkg::LANE_PAR_W-1:0] parity_data_pins_out,
    output logic [LANES*sram_port_pkg::LANE_PAR_W-1:0] parity_data_pins_oe
);

    localparam int DW = sram_port_pkg::LANE_DATA_W;
    localparam int PW = sram_port_pkg::LANE_PAR_W;
    localparam int BB = sram_port_pkg::BURST_BITS;
    localparam int DEPTH = 2 ** ADDR_W;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    // Refused at elaboration so that a bad build never reaches simulation
    if (ADDR_W < BB || ADDR_W > 24) begin : g_bad_addr_w
        $error("ADDR_W must lie between the burst bits and 24");
    end
    if (LANES < 1) begin : g_bad_lanes
        $error("LANES must be at least one");
    end
    if (sram_port_pkg::BURST_LEN != 2 ** BB) begin : g_bad_burst_len
        $error("Burst length must equal two to the burst bits");
    end
    // The pipeline below has exactly two register stages before the data cycle
    if (sram_port_pkg::DATA_LATENCY != 2) begin : g_bad_latency
        $error("Data latency must be two cycles");
    end
    // Lane words are packed as parity above data
    if (sram_port_pkg::LANE_W != DW + PW) begin : g_bad_lane_w
        $error("Lane width must be data plus parity");
    end

    // ****************************************************************
    // Command decode of the current edge
    // ****************************************************************
    logic advance;
    logic selected;
    logic load_op;
    logic load_desel;
    logic step_op;

    // Whole device is selected only when all three selects are true
    function automatic logic chip_selected(input logic sel_a_n, input logic sel_b_n,
                                           input logic sel_hi);
        chip_selected = !sel_a_n && !sel_b_n && sel_hi;
    endfunction

    assign advance = advance_or_load;
    assign selected = chip_selected(chip_sel_a_n, chip_sel_b_n, chip_sel_hi);
    assign load_op = !advance && selected;
    assign load_desel = !advance && !selected;

    // ****************************************************************
    // Burst counter
    // ****************************************************************
    sram_port_pkg::burst_state_t burst_state_q;
    sram_port_pkg::burst_state_t burst_state_d;
    logic [ADDR_W-1:0] burst_base_q;
    logic [BB-1:0] burst_count_q;
    logic [BB-1:0] burst_count_d;
    logic [BB-1:0] beat_bits;

    assign step_op = advance && (burst_state_q != sram_port_pkg::BURST_IDLE);
    // Counter wraps after four beats, repeating the same order
    assign burst_count_d = burst_count_q + sram_port_pkg::BURST_STEP;

    burst_addr_gen u_beat (
        .start_bits(burst_base_q[BB-1:0]),
        .beat_count(burst_count_d),
        .interleaved(burst_order_sel),
        .beat_bits(beat_bits)
    );

    always_comb begin
        burst_state_d = burst_state_q;
        if (load_op) begin
            if (read_write) begin
                burst_state_d = sram_port_pkg::BURST_READ;
            end else begin
                burst_state_d = sram_port_pkg::BURST_WRITE;
            end
        end else if (load_desel) begin
            // Deselect ends any burst in progress
            burst_state_d = sram_port_pkg::BURST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            burst_state_q <= sram_port_pkg::BURST_IDLE;
        end else if (!clk_enable_n) begin
            burst_state_q <= burst_state_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            burst_base_q <= '0;
            burst_count_q <= sram_port_pkg::BURST_COUNT_RESET;
        end else if (!clk_enable_n) begin
            if (load_op) begin
                burst_base_q <= address;
                burst_count_q <= sram_port_pkg::BURST_COUNT_RESET;
            end else if (step_op) begin
                burst_count_q <= burst_count_d;
            end
        end
    end

    // ****************************************************************
    // Stage one: command accepted at this edge
    // ****************************************************************
    sram_port_pkg::op_t op_d;
    logic [ADDR_W-1:0] addr_d;
    logic [LANES-1:0] mask_d;
    sram_port_pkg::op_t op1_q;
    logic [ADDR_W-1:0] addr1_q;
    logic [LANES-1:0] mask1_q;

    always_comb begin
        op_d = sram_port_pkg::OP_NONE;
        addr_d = burst_base_q;
        if (load_op) begin
            addr_d = address;
            if (read_write) begin
                op_d = sram_port_pkg::OP_READ;
            end else begin
                op_d = sram_port_pkg::OP_WRITE;
            end
        end else if (step_op) begin
            // External address is ignored while advancing
            addr_d = {burst_base_q[ADDR_W-1:BB], beat_bits};
            if (burst_state_q == sram_port_pkg::BURST_READ) begin
                op_d = sram_port_pkg::OP_READ;
            end else begin
                op_d = sram_port_pkg::OP_WRITE;
            end
        end
    end

    // Lane selects count on writes only, sampled afresh on each beat
    always_comb begin
        if (op_d == sram_port_pkg::OP_WRITE) begin
            mask_d = ~byte_lane_write_n;
        end else begin
            mask_d = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            op1_q <= sram_port_pkg::OP_NONE;
            addr1_q <= '0;
            mask1_q <= '0;
        end else if (!clk_enable_n) begin
            op1_q <= op_d;
            addr1_q <= addr_d;
            mask1_q <= mask_d;
        end
    end

    // ****************************************************************
    // Stage two: data cycle follows the next edge
    // ****************************************************************
    // A read one beat behind a write to the same word sees the new data:
    // the write commits one edge before the read looks into the array
    sram_port_pkg::op_t op2_q;
    logic [ADDR_W-1:0] addr2_q;
    logic [LANES-1:0] mask2_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            op2_q <= sram_port_pkg::OP_NONE;
            addr2_q <= '0;
            mask2_q <= '0;
        end else if (!clk_enable_n) begin
            // Pending operations move on even after a deselect
            op2_q <= op1_q;
            addr2_q <= addr1_q;
            mask2_q <= mask1_q;
        end
    end

    // ****************************************************************
    // Array lanes, write commit and read capture
    // ****************************************************************
    logic [LANES*DW-1:0] rd_data_q;
    logic [LANES*PW-1:0] rd_par_q;

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [sram_port_pkg::LANE_W-1:0] lane_mem [DEPTH];

        // Write data sampled at the edge two after its command
        always_ff @(posedge clk) begin
            if (!clk_enable_n && op2_q == sram_port_pkg::OP_WRITE && mask2_q[g]) begin
                lane_mem[addr2_q] <= {parity_data_pins_in[g*PW +: PW],
                                      data_pins_in[g*DW +: DW]};
            end
        end

        // Read data registered at the same edge, driven in the following cycle
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                rd_data_q[g*DW +: DW] <= '0;
                rd_par_q[g*PW +: PW] <= '0;
            end else if (!clk_enable_n && op2_q == sram_port_pkg::OP_READ) begin
                rd_data_q[g*DW +: DW] <= lane_mem[addr2_q][DW-1:0];
                rd_par_q[g*PW +: PW] <= lane_mem[addr2_q][DW +: PW];
            end
        end
    end

    // ****************************************************************
    // Bus drive control
    // ****************************************************************
    logic drive_q;

    // Drive only for reads; writes and deselects release the bus two cycles on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_q <= 1'b0;
        end else if (!clk_enable_n) begin
            drive_q <= (op2_q == sram_port_pkg::OP_READ);
        end
    end

    assign data_pins_out = rd_data_q;
    assign parity_data_pins_out = rd_par_q;
    // Output enable gates the pins without the clock
    assign data_pins_oe = {(LANES*DW){drive_q && !output_enable_n}};
    assign parity_data_pins_oe = {(LANES*PW){drive_q && !output_enable_n}};

endmodule // sram_burst_port
`default_nettype wire

// ===== sram_port_props.sv
// Pin-level checks of the pipelined burst SRAM port
`default_nettype none
module sram_port_props #(
    parameter int LANES = sram_port_pkg::LANES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Commands
    input wire logic clk_enable_n,
    input wire logic advance_or_load,
    input wire logic read_write,
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_b_n,
    input wire logic chip_sel_hi,
    input wire logic output_enable_n,
    // Data pins
    input wire logic [LANES*sram_port_pkg::LANE_DATA_W-1:0] data_pins_out,
    input wire logic [LANES*sram_port_pkg::LANE_DATA_W-1:0] data_pins_oe,
    input wire logic [LANES*sram_port_pkg::LANE_PAR_W-1:0] parity_data_pins_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Decoded cycles
    // ****
    wire en = !clk_enable_n;
    wire sel = !chip_sel_a_n && !chip_sel_b_n && chip_sel_hi;
    wire ld = en && !advance_or_load;
    wire ld_rd = ld && sel && read_write;
    wire ld_wr = ld && sel && !read_write;
    wire dsel = ld && !sel;
    wire drv = &data_pins_oe;
    wire off = data_pins_oe == '0;
    wire shown = output_enable_n || drv;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ****
    // Assertions
    // ****
    chk_oe_gate: assert property (output_enable_n |-> off)
        else $error("data driven while output enable is high");
    chk_lane_oe: assert property ((off || drv) &&
        parity_data_pins_oe == {LANES{data_pins_oe[0]}}) else $error("lane enables differ");
    chk_read_lat: assert property (ld_rd ##1 en ##1 en |=> shown)
        else $error("read data missing two cycles after load");
    chk_write_quiet: assert property (ld_wr ##1 en ##1 en |=> off)
        else $error("bus driven in a write data cycle");
    chk_desel_float: assert property (dsel ##1 en ##1 en |=> off)
        else $error("bus not released two cycles after deselect");
    chk_freeze_hold: assert property (!en |=> $stable(data_pins_out) &&
        ($changed(output_enable_n) || $stable(data_pins_oe))) else $error("frozen edge acted");
    chk_pend_read: assert property (ld_rd ##1 dsel ##1 en |=> shown)
        else $error("pending read dropped by deselect");
    chk_burst_beat: assert property (
        ld_rd ##1 (en && advance_or_load) ##1 en ##1 en |=> shown)
        else $error("burst beat not driven");
    cover property (ld_rd ##1 en ##1 en ##1 drv);
    cover property (dsel ##1 en ##1 en ##1 off);
    cover property (!en && drv);
endmodule // sram_port_props
bind sram_burst_port sram_port_props #(.LANES(LANES)) sram_port_props_i (
    .clk(clk),
    .reset_n(reset_n),
    .clk_enable_n(clk_enable_n),
    .advance_or_load(advance_or_load),
    .read_write(read_write),
    .chip_sel_a_n(chip_sel_a_n),
    .chip_sel_b_n(chip_sel_b_n),
    .chip_sel_hi(chip_sel_hi),
    .output_enable_n(output_enable_n),
    .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe),
    .parity_data_pins_oe(parity_data_pins_oe)
);
`default_nettype wire

// ===== bus_ctl_model.sv
// Controller model that issues commands and write data to the SRAM port
`default_nettype none
module bus_ctl_model (
    // Clock
    input wire logic clk,
    // Command pins, selects packed as a_n, b_n, hi
    output logic clk_enable_n,
    output logic advance_or_load,
    output logic read_write,
    output logic [17:0] address,
    output logic [2:0] sels,
    output logic [3:0] byte_lane_write_n,
    // Write data: parity nibble above 32 data bits
    output logic [35:0] wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_now;
    logic wr_q;
    logic [35:0] wd_now;
    logic [35:0] wd_q;
    initial begin
        clk_enable_n = 1'b0;
        {advance_or_load, sels, wr_now, wr_q} = 6'h14;
        {read_write, address, byte_lane_write_n} = 23'h00_0000;
        {wdata, wd_now, wd_q} = '0;
    end
    // Data follows its beat by two enabled edges; the bus toggles when unused
    always @(posedge clk) begin
        if (!clk_enable_n) begin
            wr_q <= wr_now;
            wd_q <= wd_now;
            wdata <= wr_q ? wd_q : ~wdata;
        end
    end
    task automatic cmd(input logic [1:0] op, input logic [2:0] s, input logic [17:0] a,
                       input logic [3:0] m, input logic [35:0] d);
        @(posedge clk);
        {advance_or_load, read_write} <= op;
        sels <= s;
        address <= a;
        byte_lane_write_n <= m; // Lane selects valid on every beat
        wr_now <= !op[0];
        wd_now <= d;
    endtask
    task automatic freeze(input int n);
        @(posedge clk);
        clk_enable_n <= 1'b1;
        repeat (n) @(posedge clk);
        clk_enable_n <= 1'b0;
    endtask
endmodule // bus_ctl_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the pipelined burst SRAM port
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] SEL = 3'h1;
    localparam logic [17:0] AD = 18'h0_0040;
    logic clk;
    logic reset_n;
    logic burst_order_sel;
    logic output_enable_n;
    logic en;
    int err_count;
    int n_checks;
    logic [35:0] shadow [int];
    logic [35:0] got [$];
    logic [35:0] exp_q [$];
    wire cen_n, adv, rw;
    wire [17:0] addr;
    wire [2:0] sels;
    wire [3:0] lanes_n, rd_par, rd_par_oe;
    wire [35:0] wdata;
    wire [31:0] rd_data, rd_oe;
    bus_ctl_model bus_ctl_model_i (.clk(clk), .clk_enable_n(cen_n), .advance_or_load(adv),
        .read_write(rw), .address(addr), .sels(sels), .byte_lane_write_n(lanes_n),
        .wdata(wdata));
    sram_burst_port sram_burst_port_i (.clk(clk), .reset_n(reset_n), .clk_enable_n(cen_n),
        .advance_or_load(adv), .read_write(rw), .address(addr), .chip_sel_a_n(sels[2]),
        .chip_sel_b_n(sels[1]), .chip_sel_hi(sels[0]), .byte_lane_write_n(lanes_n),
        .burst_order_sel(burst_order_sel), .output_enable_n(output_enable_n),
        .data_pins_in(wdata[31:0]), .data_pins_out(rd_data), .data_pins_oe(rd_oe),
        .parity_data_pins_in(wdata[35:32]), .parity_data_pins_out(rd_par),
        .parity_data_pins_oe(rd_par_oe));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Collect every word driven after an enabled edge
    always @(posedge clk) begin
        en = !cen_n;
        #1;
        if (en && &rd_oe) got.push_back({rd_par, rd_data});
    end
    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] want);
        n_checks++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [17:0] beat(input logic [17:0] a, input int n);
        return {a[17:2], burst_order_sel ? a[1:0] ^ 2'(n) : a[1:0] + 2'(n)};
    endfunction
    task automatic wr(input logic [17:0] a, input logic [3:0] m, input logic [35:0] d);
        bus_ctl_model_i.cmd(2'h0, SEL, a, m, d);
        for (int i = 0; i < 4; i++) begin
            logic [35:0] lane;
            lane = (36'h0_0000_00FF << (8 * i)) | (36'h1_0000_0000 << i);
            if (!m[i]) shadow[a] = (shadow[a] & ~lane) | (d & lane);
        end
    endtask
    task automatic rd(input logic [17:0] a);
        bus_ctl_model_i.cmd(2'h1, SEL, a, 4'h0, 36'h0_0000_0000);
        exp_q.push_back(shadow[a]);
    endtask
    task automatic drain(input string what);
        bus_ctl_model_i.cmd(2'h1, 3'h0, AD, 4'hF, 36'h0_0000_0000);
        repeat (4) @(posedge clk);
        #2;
        chk({what, " count"}, 36'(got.size()), 36'(exp_q.size()));
        foreach (exp_q[i]) if (i < got.size()) chk(what, got[i], exp_q[i]);
        got.delete();
        exp_q.delete();
    endtask
    task automatic t_rw;
        shadow[AD] = '0;
        wr(AD, 4'h0, 36'hF_0123_4567);
        rd(AD);
        wr(AD, 4'hA, 36'h0_89AB_CDEF);
        rd(AD);
        drain("write then read");
    endtask
    task automatic t_burst(input logic o, input logic [17:0] a0);
        @(posedge clk);
        burst_order_sel <= o; // Changed only while idle
        @(posedge clk);
        shadow[a0] = '0;
        wr(a0, 4'h0, 36'h1_1111_1111);
        for (int n = 1; n < 4; n++) begin
            bus_ctl_model_i.cmd(2'h2, SEL, 18'h3_FFFF, 4'h0, 36'((n + 1) * 36'h1_1111_1111));
            shadow[beat(a0, n)] = 36'((n + 1) * 36'h1_1111_1111);
        end
        for (int n = 0; n < 4; n++) rd(beat(a0, n));
        rd(a0);
        for (int n = 1; n < 5; n++) begin
            bus_ctl_model_i.cmd(2'h3, SEL, 18'h3_FFFF, 4'h0, 36'h0_0000_0000);
            exp_q.push_back(shadow[beat(a0, n)]);
        end
        drain("burst beat");
    endtask
    task automatic t_desel;
        logic [2:0] pats [3] = '{3'h5, 3'h3, 3'h0};
        foreach (pats[p]) begin
            rd(AD);
            bus_ctl_model_i.cmd(2'h0, pats[p], AD, 4'h0, 36'h0_0000_0000);
            rd(AD);
            drain("deselect");
        end
        // An advance straight after a deselect must not revive the burst
        rd(AD);
        bus_ctl_model_i.cmd(2'h0, 3'h0, AD, 4'h0, 36'h0_0000_0000);
        bus_ctl_model_i.cmd(2'h3, SEL, AD, 4'h0, 36'h0_0000_0000);
        drain("advance after deselect");
    endtask
    task automatic t_freeze;
        // Freeze while read data is driven; the last read stands again afterwards
        rd(18'h0_0102);
        rd(18'h0_0103);
        rd(18'h0_0100);
        exp_q.push_back(shadow[18'h0_0100]);
        bus_ctl_model_i.freeze(3);
        drain("frozen clock");
    endtask
    task automatic t_oe;
        @(posedge clk);
        output_enable_n <= 1'b1;
        bus_ctl_model_i.cmd(2'h1, SEL, AD, 4'h0, 36'h0_0000_0000);
        drain("output enable off");
        @(posedge clk);
        output_enable_n <= 1'b0;
    endtask
    initial begin
        err_count = 0;
        n_checks = 0;
        reset_n = 1'b0;
        burst_order_sel = 1'b0;
        output_enable_n = 1'b0; // Held low except in the output enable test
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_rw;
        t_burst(1'b0, 18'h0_0102);
        t_burst(1'b1, 18'h0_0205);
        t_desel;
        t_freeze;
        t_oe;
        close_out;
    end
    initial begin
        repeat (1000) @(posedge clk);
        err_count++;
        close_out;
    end
endmodule // tb
`default_nettype wire
